/* mwe_pkg.sv */
// ==========================================================
// constants and types of the word encoder
package mwe_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  // ==========================================================
  // word timeline, counted in half-bits (send clock periods)
  localparam logic [5:0] LAST_HALF = 6'h27;
  localparam logic [5:0] FIRST_HALF = 6'h00;
  localparam logic [5:0] SYNC_KIND_HALF = 6'h00;
  localparam logic [5:0] TX_START_HALF = 6'h01;
  localparam logic [5:0] REQ_FIRST = 6'h04;
  localparam logic [5:0] REQ_LAST = 6'h23;
  localparam logic [4:0] REQ_PERIODS = 5'h10;
  // ==========================================================
  // transmit timeline, counted in half-bits from the sync start
  localparam logic [5:0] SYNC_HALVES = 6'h06;
  localparam logic [5:0] SYNC_MID = 6'h03;
  localparam logic [5:0] PAR_HALF = 6'h26;
  // ==========================================================
  // divide-by-six: toggle every third input rising edge
  localparam logic [1:0] DIV_TERM = 2'h2;
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  typedef enum logic [0:0] {
    MWE_IDLE = 1'b0,
    MWE_RUN = 1'b1
  } mwe_run_e;

  typedef struct packed {
    logic one_n;
    logic zero_n;
  } mwe_line_s;

  typedef struct packed {
    logic valid;
    logic data;
  } mwe_bit_s;
endpackage

/* mwe_buffer.sv */
`timescale 1ns/10ps
// ==========================================================
// two-entry bit buffer, read data from a register
module mwe_buffer (
  input wire logic mclk,
  input wire logic reset,
  input wire logic flush,
  input mwe_pkg::mwe_bit_s in_bit,
  output logic in_ready,
  output mwe_pkg::mwe_bit_s out_bit,
  input wire logic out_ready
);
  typedef struct packed {
    logic [1:0] cnt;
    logic [1:0] mem;
  } mwe_buf_s;

  mwe_buf_s buf_reg;
  mwe_buf_s buf_next;
  logic push;
  logic pop;

  assign in_ready = buf_reg.cnt != mwe_pkg::BUF_DEPTH;
  assign out_bit.valid = buf_reg.cnt != 2'h0;
  assign out_bit.data = buf_reg.mem[0];
  assign push = in_bit.valid & in_ready;
  assign pop = out_ready & out_bit.valid;

  always_comb begin
    logic [1:0] idx;
    idx = buf_reg.cnt - {1'b0, pop};
    buf_next = buf_reg;
    if (pop) begin
      buf_next.mem[0] = buf_reg.mem[1];
    end
    if (push) begin
      buf_next.mem[idx[0]] = in_bit.data;
    end
    buf_next.cnt = buf_reg.cnt + {1'b0, push} - {1'b0, pop};
    if (flush) begin
      buf_next = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      buf_reg <= '0;
    end else begin
      buf_reg <= buf_next;
    end
  end

  count_bound_a: assert property (@(posedge mclk) disable iff (reset)
    buf_reg.cnt <= mwe_pkg::BUF_DEPTH)
    else $error("buffer count above depth");
endmodule

/* mwe_encoder.sv */
`timescale 1ns/10ps
module mwe_encoder (
  input wire logic mclk,
  input wire logic reset,
  input wire logic send_clk,
  input wire logic enc_clk,
  input wire logic word_start,
  input wire logic sync_kind,
  input wire logic serial_in,
  input wire logic mute_n,
  input wire logic master_clear,
  output logic shift_strobe,
  output logic data_req,
  output mwe_pkg::mwe_line_s line_n,
  output logic div6_out
);
  typedef struct packed {
    logic send_prev;
    logic enc_prev;
    logic strobe;
    logic [1:0] div_cnt;
    logic div_out;
    logic clr_pend;
    mwe_pkg::mwe_run_e word;
    logic [5:0] hcnt;
    logic cmd_sync;
    logic req;
    mwe_pkg::mwe_run_e tx;
    logic [5:0] thc;
    logic tx_cmd;
    logic cur_bit;
    logic par;
    mwe_pkg::mwe_line_s line;
  } mwe_state_s;

  mwe_state_s s_reg;
  mwe_state_s s_next;
  logic send_rise;
  logic enc_rise;
  logic clr_event;
  logic buf_in_ready;
  logic pop;
  mwe_pkg::mwe_bit_s push_bit;
  mwe_pkg::mwe_bit_s buf_out;

  assign send_rise = send_clk & ~s_reg.send_prev;
  assign enc_rise = enc_clk & ~s_reg.enc_prev;
  assign clr_event = send_rise & (s_reg.clr_pend | master_clear);

  // ==========================================================
  // bit buffer between capture and line
  mwe_buffer u_buf (
    .mclk(mclk),
    .reset(reset),
    .flush(clr_event),
    .in_bit(push_bit),
    .in_ready(buf_in_ready),
    .out_bit(buf_out),
    .out_ready(pop)
  );

  // ==========================================================
  // sequencer
  always_comb begin
    logic pos;
    logic on;
    logic [5:0] t1;
    s_next = s_reg;
    pos = 1'b0;
    on = 1'b0;
    t1 = s_reg.thc + 6'h01;
    pop = 1'b0;
    push_bit.valid = send_rise & s_reg.req & ~s_reg.strobe & ~clr_event;
    push_bit.data = serial_in;
    s_next.send_prev = send_clk;
    s_next.enc_prev = enc_clk;
    if (master_clear) begin
      s_next.div_cnt = 2'h0;
      s_next.div_out = 1'b0;
      s_next.clr_pend = 1'b1;
    end else if (enc_rise) begin
      if (s_reg.div_cnt == mwe_pkg::DIV_TERM) begin
        s_next.div_cnt = 2'h0;
        s_next.div_out = ~s_reg.div_out;
      end else begin
        s_next.div_cnt = s_reg.div_cnt + 2'h1;
      end
    end
    if (send_rise) begin
      s_next.strobe = ~s_reg.strobe;
      if (clr_event) begin
        s_next.word = mwe_pkg::MWE_IDLE;
        s_next.tx = mwe_pkg::MWE_IDLE;
        s_next.hcnt = mwe_pkg::FIRST_HALF;
        s_next.thc = mwe_pkg::FIRST_HALF;
        s_next.clr_pend = master_clear;
      end else begin
        if (s_reg.strobe && word_start && (s_reg.word == mwe_pkg::MWE_IDLE ||
            s_reg.hcnt == mwe_pkg::LAST_HALF)) begin
          s_next.word = mwe_pkg::MWE_RUN;
          s_next.hcnt = mwe_pkg::FIRST_HALF;
        end else if (s_reg.word == mwe_pkg::MWE_RUN) begin
          if (s_reg.hcnt == mwe_pkg::LAST_HALF) begin
            s_next.word = mwe_pkg::MWE_IDLE;
          end else begin
            s_next.hcnt = s_reg.hcnt + 6'h01;
          end
        end
        if (s_reg.word == mwe_pkg::MWE_RUN && s_reg.hcnt == mwe_pkg::SYNC_KIND_HALF) begin
          s_next.cmd_sync = sync_kind;
        end
        if (s_reg.word == mwe_pkg::MWE_RUN && s_reg.hcnt == mwe_pkg::TX_START_HALF) begin
          s_next.tx = mwe_pkg::MWE_RUN;
          s_next.thc = mwe_pkg::FIRST_HALF;
          s_next.tx_cmd = s_reg.cmd_sync;
          s_next.par = 1'b0;
        end else if (s_reg.tx == mwe_pkg::MWE_RUN) begin
          if (s_reg.thc == mwe_pkg::LAST_HALF) begin
            s_next.tx = mwe_pkg::MWE_IDLE;
          end else begin
            s_next.thc = t1;
          end
          if (t1 == mwe_pkg::PAR_HALF) begin
            s_next.cur_bit = ~s_reg.par;
          end else if (t1 >= mwe_pkg::SYNC_HALVES && t1 < mwe_pkg::PAR_HALF && !t1[0]) begin
            pop = 1'b1;
            s_next.cur_bit = buf_out.data;
            s_next.par = s_reg.par ^ buf_out.data;
          end
        end
      end
    end
    s_next.req = s_next.word == mwe_pkg::MWE_RUN && s_next.hcnt >= mwe_pkg::REQ_FIRST &&
      s_next.hcnt <= mwe_pkg::REQ_LAST;
    // ==========================================================
    // line drive
    if (s_next.thc < mwe_pkg::SYNC_HALVES) begin
      pos = s_next.tx_cmd ~^ (s_next.thc < mwe_pkg::SYNC_MID);
    end else begin
      pos = s_next.cur_bit ^ s_next.thc[0];
    end
    on = (s_next.tx == mwe_pkg::MWE_RUN) & mute_n;
    s_next.line.one_n = ~(on & pos);
    s_next.line.zero_n = ~(on & ~pos);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.line <= 2'h3;
    end else begin
      s_reg <= s_next;
    end
  end

  assign shift_strobe = s_reg.strobe;
  assign data_req = s_reg.req;
  assign line_n = s_reg.line;
  assign div6_out = s_reg.div_out;

  // ==========================================================
  // checks
  logic [4:0] push_cnt;
  always_ff @(posedge mclk) begin
    if (reset || !s_reg.req) begin
      push_cnt <= 5'h00;
    end else if (push_bit.valid) begin
      push_cnt <= push_cnt + 5'h01;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  word_start_a: assert property (
    send_rise && !clr_event && s_reg.strobe && word_start && s_reg.word == mwe_pkg::MWE_IDLE
    |=> s_reg.word == mwe_pkg::MWE_RUN && s_reg.hcnt == 6'h00 && !shift_strobe)
    else $error("word did not start on strobe fall");
  word_end_a: assert property (
    send_rise && !clr_event && s_reg.word == mwe_pkg::MWE_RUN &&
    s_reg.hcnt == mwe_pkg::LAST_HALF && !word_start |=> s_reg.word == mwe_pkg::MWE_IDLE)
    else $error("word did not end after twenty strobes");
  sync_sample_a: assert property (
    send_rise && !clr_event && s_reg.word == mwe_pkg::MWE_RUN && s_reg.hcnt == 6'h00
    |=> s_reg.cmd_sync == $past(sync_kind) && shift_strobe)
    else $error("sync kind not sampled at strobe rise");
  req_span_a: assert property (
    $fell(data_req) && !$past(clr_event) |-> $past(push_cnt) == mwe_pkg::REQ_PERIODS)
    else $error("data request not sixteen strobes long");
  capture_a: assert property (
    push_bit.valid |-> buf_in_ready && data_req && !shift_strobe)
    else $error("bit captured while buffer full or off request");
  parity_a: assert property (
    send_rise && !clr_event && s_reg.tx == mwe_pkg::MWE_RUN &&
    s_reg.thc + 6'h01 == mwe_pkg::PAR_HALF && s_reg.hcnt != mwe_pkg::TX_START_HALF
    |=> s_reg.cur_bit == ~$past(s_reg.par))
    else $error("parity bit not odd");
  mute_a: assert property (
    !mute_n |=> line_n.one_n && line_n.zero_n)
    else $error("line driven while muted");
  clear_a: assert property (
    send_rise && master_clear |=> s_reg.word == mwe_pkg::MWE_IDLE &&
    s_reg.tx == mwe_pkg::MWE_IDLE ##1 !data_req)
    else $error("clear did not reset encoder");
  manch_a: assert property (
    s_reg.tx == mwe_pkg::MWE_RUN && $past(mute_n) |-> line_n.one_n != line_n.zero_n)
    else $error("line halves not complementary");
  div_a: assert property (
    enc_rise && !master_clear && s_reg.div_cnt == mwe_pkg::DIV_TERM
    |=> div6_out != $past(div6_out))
    else $error("divider did not toggle");

  cmd_word_c: cover property (s_reg.tx == mwe_pkg::MWE_RUN && s_reg.tx_cmd &&
    s_reg.thc == mwe_pkg::LAST_HALF);
  back_to_back_c: cover property (send_rise && s_reg.word == mwe_pkg::MWE_RUN &&
    s_reg.hcnt == mwe_pkg::LAST_HALF && s_reg.strobe && word_start);
  abort_c: cover property (clr_event && s_reg.tx == mwe_pkg::MWE_RUN);
endmodule

/* mwe_host.sv */
`timescale 1ns/10ps
// ==========================================================
// host model: send clock, word requests, serial data
module mwe_host (
  input wire logic mclk,
  input wire logic reset,
  input wire logic shift_strobe,
  input wire logic data_req,
  output logic send_clk,
  output logic word_start,
  output logic sync_kind,
  output logic serial_in,
  output logic [16:0] sent,
  output logic sent_stb
);
  integer seed = 32'ha415;
  logic [2:0] ph = 3'h0;
  logic [15:0] word = 16'h0000, sh = 16'h0000;
  logic [7:0] gap = 8'h00;
  logic st_d = 1'b0, dr_d = 1'b0;
  int n = 0;
  initial begin
    send_clk = 1'b0;
    word_start = 1'b0;
    sync_kind = 1'b0;
    serial_in = 1'b0;
    sent = 17'h00000;
    sent_stb = 1'b0;
  end
  always @(posedge mclk) begin
    ph <= reset ? 3'h0 : ph + 3'h1;
    send_clk <= ph[2];
    st_d <= shift_strobe;
    dr_d <= data_req;
    sent_stb <= 1'b0;
    if (word_start && data_req && !dr_d) begin
      word_start <= 1'b0;
      sent <= {sync_kind, word};
      sent_stb <= 1'b1;
    end else if (!word_start && !data_req && !reset) begin
      if (gap == 8'h00) begin
        word_start <= 1'b1;
        sync_kind <= 1'($random(seed));
        word <= n == 0 ? 16'h0000 : n == 1 ? 16'hffff : 16'($random(seed));
        n <= n + 1;
        gap <= ($random(seed) & 1) ? 8'h00 : 8'($random(seed));
      end else begin
        gap <= gap - 8'h01;
      end
    end
    if (data_req && st_d && !shift_strobe) begin
      serial_in <= dr_d ? sh[15] : word[15];
      sh <= (dr_d ? sh : word) << 1;
    end else if (data_req && !dr_d) begin
      sh <= word;
    end else if (!data_req) begin
      serial_in <= ~serial_in;
    end
  end
endmodule

/* tb.sv */
`timescale 1ns/10ps
// ==========================================================
// self-checking bench of the word encoder
module tb;
  logic mclk = 1'b0, reset = 1'b1, enc_clk = 1'b0, mute_n = 1'b1, master_clear = 1'b0;
  logic send_d = 1'b0, dr_d = 1'b0, dq_s = 1'b0, ab = 1'b0, ss_d = 1'b1;
  logic send_clk, word_start, sync_kind, serial_in, shift_strobe, data_req, div6_out, sent_stb;
  mwe_pkg::mwe_line_s line_n;
  logic [16:0] sent, e;
  logic [119:0] hist = '0;
  logic [2:0] hb, ep = 3'h0;
  logic [16:0] exp_q[$];
  integer seed = 32'ha415;
  int bad_count = 0;
  int checks_done = 0;
  int c = 0, k = 99, hi = 0, er = 0, n = 0;
  initial begin
    forever #(mwe_pkg::CLK_PERIOD_NS / 2) mclk = ~mclk;
  end
  mwe_encoder i_mwe_encoder (.mclk, .reset, .send_clk, .enc_clk, .word_start, .sync_kind,
    .serial_in, .mute_n, .master_clear, .shift_strobe, .data_req, .line_n, .div6_out);
  mwe_host i_mwe_host (.mclk, .reset, .shift_strobe, .data_req, .send_clk, .word_start,
    .sync_kind, .serial_in, .sent, .sent_stb);
  task automatic chk_bit(string s, logic x, logic g);
    checks_done++;
    if (g !== x) begin
      bad_count++;
      $display("Error %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic chk_line(string s, logic [1:0] x, logic [1:0] g);
    checks_done++;
    if (g !== x) begin
      bad_count++;
      $display("Error %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic chk_cnt(string s, int x, int g);
    checks_done++;
    if (g != x) begin
      bad_count++;
      $display("Error %s expected %0d seen %0d", s, x, g);
    end
  endtask
  task automatic finish_test;
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // expected line level of half j of a word {kind, data}
  function automatic logic [1:0] half_exp(logic [16:0] w, int j);
    logic b;
    if (j < 6) return ((j < 3) ^ w[16]) ? 2'b10 : 2'b01;
    b = j < 38 ? w[15 - (j - 6) / 2] : ~^w[15:0];
    return (b ^ j[0]) ? 2'b01 : 2'b10;
  endfunction
  // ==========================================================
  // monitor: one line sample in every half bit, five clocks after its start
  always @(posedge mclk) begin
    send_d <= send_clk;
    dr_d <= data_req;
    c <= (send_clk && !send_d) ? 0 : c + 1;
    if (sent_stb) exp_q.push_back(sent);
    if (c == 5) begin
      mute_n <= ($random(seed) & 3) != 0;
      hist <= {hist[116:0], mute_n, line_n};
      dq_s <= data_req;
      ss_d <= shift_strobe;
      if (!reset) chk_bit("strobe", ~ss_d, shift_strobe);
      k <= ab ? 99 : (data_req && !dq_s) ? 0 : k + 1;
      if (k == 37 && exp_q.size() > 0) begin
        e = exp_q.pop_front();
        for (int j = 0; j < 40; j++) begin
          hb = hist[3 * (39 - j) +: 3];
          chk_line("line", hb[2] ? half_exp(e, j) : 2'b11, hb[1:0]);
        end
      end
    end
    if (data_req) hi <= hi + 1;
    else begin
      if (dr_d && !ab) chk_cnt("req_len", 256, hi);
      hi <= 0;
    end
    ep <= reset ? 3'h0 : ep + 3'h1;
    enc_clk <= ep[2];
    if (reset || master_clear) er <= 0;
    else if (ep == 3'h4) er <= er + 1;
    if (ep == 3'h3 && !reset && !master_clear) chk_bit("div6", 1'((er / 3) % 2), div6_out);
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge mclk);
    #1;
    chk_line("reset line", 2'b11, line_n);
    chk_bit("reset req", 1'b0, data_req);
    chk_bit("reset strobe", 1'b0, shift_strobe);
    @(posedge mclk);
    reset <= 1'b0;
    repeat (9000) @(posedge mclk);
    while (!(hi > 40 && ep == 3'h0) && n < 800) begin
      @(posedge mclk);
      n++;
    end
    ab <= 1'b1;
    master_clear <= 1'b1;
    repeat (8) @(posedge mclk);
    master_clear <= 1'b0;
    n = 0;
    while (data_req && n < 24) begin
      @(posedge mclk);
      n++;
    end
    #1;
    chk_bit("abort req", 1'b0, data_req);
    chk_line("abort line", 2'b11, line_n);
    repeat (16) @(posedge mclk);
    ab <= 1'b0;
    void'(exp_q.pop_front());
    repeat (1500) @(posedge mclk);
    // short clear pulse between send rises: acted on at the next rise
    n = 0;
    while (!(hi > 40 && hi < 200 && ep == 3'h6) && n < 800) begin
      @(posedge mclk);
      n++;
    end
    ab <= 1'b1;
    master_clear <= 1'b1;
    @(posedge mclk);
    master_clear <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk_bit("pending req", 1'b1, data_req);
    repeat (2) @(posedge mclk);
    #1;
    chk_bit("late abort req", 1'b0, data_req);
    chk_line("late abort line", 2'b11, line_n);
    repeat (16) @(posedge mclk);
    ab <= 1'b0;
    void'(exp_q.pop_front());
    repeat (1500) @(posedge mclk);
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    finish_test();
  end
endmodule
